/* include/dce_defines.vh */
// Constants for the DMA channel enable, flow decode, identification and test block
// Behaviour
// - Enable bit zero starts channel, reads state
// - Clear waits transfer end, then flushes FIFO
// - Last item or error clears enable
// - Enable states mirrored in summary register
// - Three-bit flow code gives type and controller
// - Four byte-wide peripheral ident registers, read-only
// - Part code low twelve, maker code next
// - Revision four bits, configuration in top byte
// - Four component ident registers, low byte only
// - Test control bit zero selects test mode
// - Test control cleared by reset
// - Test output drives clear lines, reads mux
// - Halt ignores source requests, FIFO drains
// - Active reads one while FIFO holds data
`ifndef DCE_DEFINES_VH
`define DCE_DEFINES_VH

// Register byte offsets
`define DCE_OFS_ENSUM      12'h01c
`define DCE_OFS_IRQ_STS    12'h020
`define DCE_OFS_IRQ_CLR    12'h024
`define DCE_OFS_IRQ_EN     12'h028
`define DCE_OFS_TEST_CTRL  12'h500
`define DCE_OFS_TEST_CLR   12'h504
`define DCE_OFS_PID0       12'hfe0
`define DCE_OFS_PID1       12'hfe4
`define DCE_OFS_PID2       12'hfe8
`define DCE_OFS_PID3       12'hfec
`define DCE_OFS_CID0       12'hff0
`define DCE_OFS_CID1       12'hff4
`define DCE_OFS_CID2       12'hff8
`define DCE_OFS_CID3       12'hffc

// Channel configuration: offset 0x110 + 0x20 * channel
`define DCE_CFG_PAGE       4'h1
`define DCE_CFG_LOW        5'h10

// Configuration fields
`define DCE_CFG_EN         0
`define DCE_CFG_SRCP_HI    4
`define DCE_CFG_SRCP_LO    1
`define DCE_CFG_DSTP_HI    9
`define DCE_CFG_DSTP_LO    6
`define DCE_CFG_FLOW_HI    13
`define DCE_CFG_FLOW_LO    11
`define DCE_CFG_IE         14
`define DCE_CFG_ITC        15
`define DCE_CFG_LOCK       16
`define DCE_CFG_ACTIVE     17
`define DCE_CFG_HALT       18
`define DCE_CFG_W          19

// Flow codes
`define DCE_FLOW_MM        3'h0
`define DCE_FLOW_MP        3'h1
`define DCE_FLOW_PM        3'h2
`define DCE_FLOW_PP        3'h3
`define DCE_FLOW_PP_DST    3'h4
`define DCE_FLOW_MP_PER    3'h5
`define DCE_FLOW_PM_PER    3'h6
`define DCE_FLOW_PP_SRC    3'h7

// Flow controller encoding
`define DCE_CTL_DMA        2'h0
`define DCE_CTL_DST        2'h1
`define DCE_CTL_SRC        2'h2

// Identification field positions
`define DCE_ID_PART_HI     11
`define DCE_ID_PART_LO     0
`define DCE_ID_MAKER_HI    19
`define DCE_ID_MAKER_LO    12
`define DCE_ID_REV_HI      23
`define DCE_ID_REV_LO      20
`define DCE_ID_CONF_HI     31
`define DCE_ID_CONF_LO     24

// Reset values
`define DCE_TEST_RST       1'h0
`define DCE_CLR_RST        16'h0000
`define DCE_REV_RST        4'h0

// Test control bit
`define DCE_TEST_EN        0

`endif

/* rtl/dce_channel_ctrl.v */
// Channel enable, flow decode, identification and test registers on AHB-Lite
//
// Chosen here: the AHB-Lite slave port.
`timescale 1ns/10ps
`include "dce_defines.vh"

module dce_channel_ctrl #(
	parameter        NCH       = 8,
	parameter        NCLR      = 16,
	parameter [11:0] PART_CODE = 12'h123, // Arbitrary value
	parameter [7:0]  MAKER     = 8'h5a,   // Arbitrary value
	parameter [7:0]  CONF_OPT  = 8'h00,
	parameter [31:0] COMP_ID   = 32'h9c3e7d42 // Arbitrary value
)(
	// Clock and reset
	input  wire             hclk,
	input  wire             hresetn,
	// AHB-Lite slave
	input  wire             hsel,
	input  wire [11:0]      haddr,
	input  wire [1:0]       htrans,
	input  wire             hwrite,
	input  wire [2:0]       hsize,
	input  wire [31:0]      hwdata,
	input  wire             hready,
	output reg              hreadyout,
	output reg              hresp,
	output reg  [31:0]      hrdata,
	// Channel status from the controller
	input  wire [NCH-1:0]   chan_xfer_busy,
	input  wire [NCH-1:0]   chan_fifo_has_data,
	input  wire [NCH-1:0]   chan_last_item_done,
	input  wire [NCH-1:0]   chan_error,
	input  wire [NCH-1:0]   chan_src_req,
	input  wire [NCLR-1:0]  clear_lines_func,
	// Channel control to the controller
	output reg  [NCH-1:0]   chan_enable,
	output reg  [NCH-1:0]   chan_halt,
	output reg  [NCH-1:0]   chan_flush,
	output reg  [NCH-1:0]   chan_src_req_gated,
	output reg  [NCH-1:0]   chan_src_periph,
	output reg  [NCH-1:0]   chan_dst_periph,
	output reg  [2*NCH-1:0] chan_flow_ctl,
	output reg  [NCLR-1:0]  request_clear_outputs,
	// Interrupt
	output reg              irq
);

	reg  [`DCE_CFG_W-1:0] cfg_reg [0:NCH-1];
	reg  [NCH-1:0]        pend_reg;
	reg  [2*NCH-1:0]      sts_reg;
	reg  [2*NCH-1:0]      irq_en_reg;
	reg                   test_mode_control_reg;
	reg  [NCLR-1:0]       test_output_clear_lines_reg;
	reg                   ph_reg;
	reg                   ph_write_reg;
	reg  [11:0]           ph_addr_reg;
	reg  [31:0]           rdata_next;
	reg  [2*NCH-1:0]      sts_set;
	reg  [2*NCH-1:0]      sts_clr;
	wire                  addr_phase;
	wire                  wr_phase;
	wire [2:0]            cidx;
	wire                  cfg_hit;
	wire [31:0]           periph_id;
	integer               i;
	integer               j;

	assign addr_phase = hsel & htrans[1] & hready;
	assign wr_phase   = ph_reg & ph_write_reg;
	assign cidx       = ph_addr_reg[7:5];
	assign cfg_hit    = (ph_addr_reg[11:8] == `DCE_CFG_PAGE) &&
	                    (ph_addr_reg[4:0] == `DCE_CFG_LOW) && (cidx < NCH);

	// Combined peripheral identification word
	assign periph_id[`DCE_ID_PART_HI:`DCE_ID_PART_LO]   = PART_CODE;
	assign periph_id[`DCE_ID_MAKER_HI:`DCE_ID_MAKER_LO] = MAKER;
	assign periph_id[`DCE_ID_REV_HI:`DCE_ID_REV_LO]     = `DCE_REV_RST;
	assign periph_id[`DCE_ID_CONF_HI:`DCE_ID_CONF_LO]   = CONF_OPT;

	// Bus handshake: one wait state per transfer
	always @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			ph_reg       <= 1'b0;
			ph_write_reg <= 1'b0;
			ph_addr_reg  <= 12'h000;
			hreadyout    <= 1'b1;
			hresp        <= 1'b0;
			hrdata       <= 32'h00000000;
		end
		else
		begin
			hresp <= 1'b0;
			if (ph_reg)
			begin
				ph_reg    <= 1'b0;
				hreadyout <= 1'b1;
				hrdata    <= rdata_next;
			end
			else if (addr_phase)
			begin
				ph_reg       <= 1'b1;
				ph_write_reg <= hwrite;
				ph_addr_reg  <= {haddr[11:2], 2'b00};
				hreadyout    <= 1'b0;
			end
		end
	end

	// Read multiplexer
	always @*
	begin
		rdata_next = 32'h00000000;
		if (ph_write_reg)
			rdata_next = 32'h00000000;
		else if (cfg_hit)
		begin
			rdata_next[`DCE_CFG_W-1:0]   = cfg_reg[cidx];
			rdata_next[`DCE_CFG_EN]      = chan_enable[cidx];
			rdata_next[`DCE_CFG_HALT]    = chan_halt[cidx];
			rdata_next[`DCE_CFG_ACTIVE]  = chan_fifo_has_data[cidx];
		end
		else if (ph_addr_reg == `DCE_OFS_ENSUM)
			rdata_next[NCH-1:0] = chan_enable;
		else if (ph_addr_reg == `DCE_OFS_IRQ_STS)
			rdata_next[2*NCH-1:0] = sts_reg;
		else if (ph_addr_reg == `DCE_OFS_IRQ_EN)
			rdata_next[2*NCH-1:0] = irq_en_reg;
		else if (ph_addr_reg == `DCE_OFS_TEST_CTRL)
			rdata_next[`DCE_TEST_EN] = test_mode_control_reg;
		else if (ph_addr_reg == `DCE_OFS_TEST_CLR)
			rdata_next[NCLR-1:0] = request_clear_outputs;
		else if (ph_addr_reg == `DCE_OFS_PID0)
			rdata_next[7:0] = periph_id[7:0];
		else if (ph_addr_reg == `DCE_OFS_PID1)
			rdata_next[7:0] = periph_id[15:8];
		else if (ph_addr_reg == `DCE_OFS_PID2)
			rdata_next[7:0] = periph_id[23:16];
		else if (ph_addr_reg == `DCE_OFS_PID3)
			rdata_next[7:0] = periph_id[31:24];
		else if (ph_addr_reg == `DCE_OFS_CID0)
			rdata_next[7:0] = COMP_ID[7:0];
		else if (ph_addr_reg == `DCE_OFS_CID1)
			rdata_next[7:0] = COMP_ID[15:8];
		else if (ph_addr_reg == `DCE_OFS_CID2)
			rdata_next[7:0] = COMP_ID[23:16];
		else if (ph_addr_reg == `DCE_OFS_CID3)
			rdata_next[7:0] = COMP_ID[31:24];
	end

	// Channel enable, halt and configuration storage
	always @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			for (j = 0; j < NCH; j = j + 1)
				cfg_reg[j] <= {`DCE_CFG_W{1'b0}};
			chan_enable <= {NCH{1'b0}};
			chan_halt   <= {NCH{1'b0}};
			pend_reg    <= {NCH{1'b0}};
			chan_flush  <= {NCH{1'b0}};
		end
		else
		begin
			chan_flush <= {NCH{1'b0}};
			if (wr_phase && cfg_hit)
			begin
				cfg_reg[cidx]   <= hwdata[`DCE_CFG_W-1:0];
				chan_halt[cidx] <= hwdata[`DCE_CFG_HALT];
				if (hwdata[`DCE_CFG_EN])
				begin
					chan_enable[cidx] <= 1'b1;
					pend_reg[cidx]    <= 1'b0;
				end
				else if (chan_enable[cidx])
					pend_reg[cidx] <= 1'b1;
			end
			for (j = 0; j < NCH; j = j + 1)
			begin
				if (pend_reg[j] && !chan_xfer_busy[j])
				begin
					chan_enable[j] <= 1'b0;
					pend_reg[j]    <= 1'b0;
					chan_flush[j]  <= 1'b1;
				end
				if (chan_enable[j] && (chan_last_item_done[j] || chan_error[j]))
				begin
					chan_enable[j] <= 1'b0;
					pend_reg[j]    <= 1'b0;
				end
			end
		end
	end

	// Flow decode and request gating
	always @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			chan_src_periph    <= {NCH{1'b0}};
			chan_dst_periph    <= {NCH{1'b0}};
			chan_flow_ctl      <= {2*NCH{1'b0}};
			chan_src_req_gated <= {NCH{1'b0}};
		end
		else
		begin
			for (i = 0; i < NCH; i = i + 1)
			begin
				chan_src_req_gated[i] <= chan_src_req[i] & chan_enable[i] &
				                         ~chan_halt[i];
				case (cfg_reg[i][`DCE_CFG_FLOW_HI:`DCE_CFG_FLOW_LO])
				`DCE_FLOW_MM:
				begin
					chan_src_periph[i] <= 1'b0;
					chan_dst_periph[i] <= 1'b0;
					chan_flow_ctl[2*i +: 2] <= `DCE_CTL_DMA;
				end
				`DCE_FLOW_MP:
				begin
					chan_src_periph[i] <= 1'b0;
					chan_dst_periph[i] <= 1'b1;
					chan_flow_ctl[2*i +: 2] <= `DCE_CTL_DMA;
				end
				`DCE_FLOW_PM:
				begin
					chan_src_periph[i] <= 1'b1;
					chan_dst_periph[i] <= 1'b0;
					chan_flow_ctl[2*i +: 2] <= `DCE_CTL_DMA;
				end
				`DCE_FLOW_PP:
				begin
					chan_src_periph[i] <= 1'b1;
					chan_dst_periph[i] <= 1'b1;
					chan_flow_ctl[2*i +: 2] <= `DCE_CTL_DMA;
				end
				`DCE_FLOW_PP_DST:
				begin
					chan_src_periph[i] <= 1'b1;
					chan_dst_periph[i] <= 1'b1;
					chan_flow_ctl[2*i +: 2] <= `DCE_CTL_DST;
				end
				`DCE_FLOW_MP_PER:
				begin
					chan_src_periph[i] <= 1'b0;
					chan_dst_periph[i] <= 1'b1;
					chan_flow_ctl[2*i +: 2] <= `DCE_CTL_DST;
				end
				`DCE_FLOW_PM_PER:
				begin
					chan_src_periph[i] <= 1'b1;
					chan_dst_periph[i] <= 1'b0;
					chan_flow_ctl[2*i +: 2] <= `DCE_CTL_SRC;
				end
				default:
				begin
					chan_src_periph[i] <= 1'b1;
					chan_dst_periph[i] <= 1'b1;
					chan_flow_ctl[2*i +: 2] <= `DCE_CTL_SRC;
				end
				endcase
			end
		end
	end

	// Interrupt events: completion in low half, error in high half
	always @*
	begin
		sts_set = {chan_error & chan_enable, chan_last_item_done & chan_enable};
		sts_clr = {2*NCH{1'b0}};
		if (wr_phase && (ph_addr_reg == `DCE_OFS_IRQ_CLR))
			sts_clr = hwdata[2*NCH-1:0];
	end

	always @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			sts_reg    <= {2*NCH{1'b0}};
			irq_en_reg <= {2*NCH{1'b0}};
			irq        <= 1'b0;
		end
		else
		begin
			sts_reg <= (sts_reg & ~sts_clr) | sts_set;
			if (wr_phase && (ph_addr_reg == `DCE_OFS_IRQ_EN))
				irq_en_reg <= hwdata[2*NCH-1:0];
			irq <= |(((sts_reg & ~sts_clr) | sts_set) & irq_en_reg);
		end
	end

	// Test mode registers and clear line multiplexer
	always @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			test_mode_control_reg       <= `DCE_TEST_RST;
			test_output_clear_lines_reg <= `DCE_CLR_RST;
			request_clear_outputs       <= `DCE_CLR_RST;
		end
		else
		begin
			if (wr_phase && (ph_addr_reg == `DCE_OFS_TEST_CTRL))
				test_mode_control_reg <= hwdata[`DCE_TEST_EN];
			if (wr_phase && (ph_addr_reg == `DCE_OFS_TEST_CLR))
				test_output_clear_lines_reg <= hwdata[NCLR-1:0];
			if (test_mode_control_reg)
				request_clear_outputs <= test_output_clear_lines_reg;
			else
				request_clear_outputs <= clear_lines_func;
		end
	end

endmodule // dce_channel_ctrl

/* test/dce_channel_ctrl_monitor.sv */
// Port checks for the channel control block
`timescale 1ns/10ps
module dce_channel_ctrl_monitor #(parameter NCH = 8)(
	// Clock, reset and bus
	input wire           hclk,
	input wire           hresetn,
	input wire           hreadyout,
	// Channel side
	input wire [NCH-1:0] chan_xfer_busy,
	input wire [NCH-1:0] chan_last_item_done,
	input wire [NCH-1:0] chan_error,
	input wire [NCH-1:0] chan_src_req,
	input wire [NCH-1:0] chan_enable,
	input wire [NCH-1:0] chan_halt,
	input wire [NCH-1:0] chan_flush,
	input wire [NCH-1:0] chan_src_req_gated
);
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	wire [NCH-1:0] hw_end = chan_last_item_done | chan_error;
	wire [NCH-1:0] end_en = chan_enable & hw_end;
	wire [NCH-1:0] hold_en = chan_enable & chan_xfer_busy & ~hw_end;
	wire [NCH-1:0] gate_src = chan_src_req & chan_enable & ~chan_halt;
	a_rise_by_write: assert property (((chan_enable & ~$past(chan_enable)) != 0) |-> $past(hreadyout) == 1'b0)
		else $error("enable rose outside a write");
	a_drop_cause: assert property ((($past(chan_enable) & ~chan_enable) & ~chan_flush & ~$past(hw_end)) == 0)
		else $error("enable dropped without cause");
	a_flush_cause: assert property ((chan_flush & ~($past(chan_enable) & ~chan_enable)) == 0)
		else $error("flush without disable");
	a_flush_pulse: assert property ((chan_flush & $past(chan_flush)) == 0)
		else $error("flush longer than one cycle");
	a_busy_holds: assert property (($past(hold_en) & ~chan_enable) == 0)
		else $error("disabled during transfer");
	a_end_clears: assert property (($past(end_en) & chan_enable) == 0)
		else $error("enable kept after end or error");
	a_gate_req: assert property (chan_src_req_gated == $past(gate_src))
		else $error("gated request wrong");
	a_halt_blocks: assert property ((chan_src_req_gated & $past(chan_halt)) != 0 |-> 1'b0)
		else $error("request passed while halted");
endmodule // dce_channel_ctrl_monitor

bind dce_channel_ctrl dce_channel_ctrl_monitor #(.NCH(NCH)) u_mon (.hclk(hclk),
	.hresetn(hresetn), .hreadyout(hreadyout), .chan_xfer_busy(chan_xfer_busy),
	.chan_last_item_done(chan_last_item_done), .chan_error(chan_error),
	.chan_src_req(chan_src_req), .chan_enable(chan_enable), .chan_halt(chan_halt),
	.chan_flush(chan_flush), .chan_src_req_gated(chan_src_req_gated));

/* test/dce_far_model.sv */
// Far-side channel engine: requests, bus activity and FIFO fill
`timescale 1ns/10ps
module dce_far_model #(parameter NCH = 8)(
	// Clock and reset
	input  wire           hclk,
	input  wire           hresetn,
	// From the block
	input  wire [NCH-1:0] chan_flush,
	input  wire [NCH-1:0] chan_src_req_gated,
	// Scenario control
	input  wire           slow,
	input  wire [NCH-1:0] end_cmd,
	input  wire [NCH-1:0] err_cmd,
	// To the block
	output reg  [NCH-1:0] chan_xfer_busy,
	output reg  [NCH-1:0] chan_fifo_has_data,
	output reg  [NCH-1:0] chan_last_item_done,
	output reg  [NCH-1:0] chan_error,
	output reg  [NCH-1:0] chan_src_req
);
	reg [3:0] bcnt [0:NCH-1];
	reg [3:0] fill [0:NCH-1];
	integer   i;
	integer   j;
	always @*
		for (i = 0; i < NCH; i = i + 1)
		begin
			chan_xfer_busy[i] = bcnt[i] != 4'h0;
			chan_fifo_has_data[i] = fill[i] != 4'h0;
		end
	always @(posedge hclk or negedge hresetn)
		if (!hresetn)
		begin
			chan_src_req <= 0;
			chan_last_item_done <= 0;
			chan_error <= 0;
			for (j = 0; j < NCH; j = j + 1)
			begin
				bcnt[j] <= 4'h0;
				fill[j] <= 4'h0;
			end
		end
		else
		begin
			chan_src_req <= NCH'($urandom);
			chan_last_item_done <= end_cmd;
			chan_error <= err_cmd;
			for (j = 0; j < NCH; j = j + 1)
			begin
				if (bcnt[j] != 4'h0)
					bcnt[j] <= bcnt[j] - 4'h1;
				else if (chan_src_req_gated[j])
					bcnt[j] <= slow ? 4'hc : 4'h3;
				if (chan_flush[j])
					fill[j] <= 4'h0;
				else if (bcnt[j] == 4'h1 && fill[j] != 4'hf)
					fill[j] <= fill[j] + 4'h1;
				else if (bcnt[j] == 4'h0 && fill[j] != 4'h0)
					fill[j] <= fill[j] - 4'h1;
			end
		end
endmodule // dce_far_model

/* test/dce_channel_ctrl_bench.sv */
// Self-checking bench for the channel control block
`timescale 1ns/10ps
`include "dce_defines.vh"
module dce_channel_ctrl_bench;
	localparam [11:0] PART = 12'h2b7; // Arbitrary value
	localparam [7:0]  MKR = 8'h3c;    // Arbitrary value
	localparam [31:0] CID = 32'h1e2d3c4b; // Arbitrary value
	localparam [31:0] PID = {8'h11, 4'h0, MKR, PART};
	localparam [31:0] ALL = 32'hffffffff;
	reg          hclk = 0, hresetn = 0, hwrite = 0, slow = 0, rd_dp = 0;
	reg  [11:0]  haddr = 0, ca;
	reg  [1:0]   htrans = 0;
	reg  [31:0]  hwdata = 0, rdat;
	reg  [15:0]  clf = 0, v, w;
	reg  [7:0]   end_cmd = 0, err_cmd = 0;
	reg  [63:0]  t;
	reg  [63:0]  exp_q[$];
	wire         hreadyout, irq, hresp;
	wire [31:0]  hrdata;
	wire [7:0]   busy, fifo, lst, err, sreq, en, fl, gsr, sp, dp, hlt;
	wire [15:0]  fctl, rco;
	integer      n_errors = 0, n_compared = 0, i, k, c;
	dce_channel_ctrl #(.PART_CODE(PART), .MAKER(MKR), .CONF_OPT(8'h11), .COMP_ID(CID)) dut (
		.hclk(hclk), .hresetn(hresetn), .hsel(1'b1), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
		.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .chan_xfer_busy(busy),
		.chan_fifo_has_data(fifo), .chan_last_item_done(lst), .chan_error(err),
		.chan_src_req(sreq), .clear_lines_func(clf), .chan_enable(en), .chan_halt(hlt),
		.chan_flush(fl), .chan_src_req_gated(gsr), .chan_src_periph(sp),
		.chan_dst_periph(dp), .chan_flow_ctl(fctl), .request_clear_outputs(rco), .irq(irq));
	dce_far_model far (.hclk(hclk), .hresetn(hresetn), .chan_flush(fl),
		.chan_src_req_gated(gsr), .slow(slow), .end_cmd(end_cmd), .err_cmd(err_cmd),
		.chan_xfer_busy(busy), .chan_fifo_has_data(fifo), .chan_last_item_done(lst),
		.chan_error(err), .chan_src_req(sreq));
	initial
		forever #5 hclk = ~hclk;
	task chk(input [31:0] got, input [31:0] exp);
		begin
			n_compared = n_compared + 1;
			if (got !== exp)
			begin
				n_errors = n_errors + 1;
				$display("Error %0t: got %h expected %h", $time, got, exp);
			end
		end
	endtask
	task report_and_stop;
		begin
			$display("Compared %0d, errors %0d", n_compared, n_errors);
			if (n_errors == 0 && n_compared > 0)
				$display("STATUS OK");
			else
				$display("STATUS NOT OK");
			$finish;
		end
	endtask
	task rdy;
		begin
			k = 0;
			do
			begin
				@(posedge hclk);
				k = k + 1;
			end
			while (hreadyout !== 1'b1 && k < 50);
			if (hreadyout !== 1'b1)
			begin
				n_errors = n_errors + 1;
				report_and_stop;
			end
		end
	endtask
	task bus(input [11:0] a, input wr, input [31:0] d, input [31:0] m, input [31:0] e);
		begin
			@(posedge hclk);
			htrans <= 2'h2;
			haddr <= a;
			hwrite <= wr;
			rdy;
			htrans <= 2'h0;
			hwdata <= d;
			rd_dp <= !wr;
			if (!wr && m != 0)
				exp_q.push_back({m, e});
			rdy;
			rdat = hrdata;
			rd_dp <= 1'b0;
		end
	endtask
	always @(posedge hclk)
		if (rd_dp && hreadyout && exp_q.size() > 0)
		begin
			t = exp_q.pop_front();
			chk(hrdata & t[63:32], t[31:0] & t[63:32]);
			chk(hresp, 0);
		end
	task until_off;
		begin
			for (k = 0; k < 60 && en[c]; k = k + 1)
				@(posedge hclk);
			chk(en[c], 0);
			if (en[c])
				report_and_stop;
		end
	endtask
	task pulse(input e);
		begin
			if (e)
				err_cmd[c] <= 1'b1;
			else
				end_cmd[c] <= 1'b1;
			@(posedge hclk);
			err_cmd <= 0;
			end_cmd <= 0;
			repeat (3) @(posedge hclk);
		end
	endtask
	initial
	begin
		void'($urandom(32'ha412));
		repeat (10) @(posedge hclk);
		hresetn <= 1'b1;
		bus(`DCE_OFS_PID0, 1, ALL, 0, 0);
		for (i = 0; i < 4; i = i + 1)
		begin
			bus(12'(`DCE_OFS_PID0 + 4 * i), 0, 0, ALL, {24'h0, PID[8*i +: 8]});
			bus(12'(`DCE_OFS_CID0 + 4 * i), 0, 0, ALL, {24'h0, CID[8*i +: 8]});
		end
		bus(12'h300, 0, 0, ALL, 0);
		v = 16'($urandom);
		w = 16'($urandom);
		clf <= v;
		bus(`DCE_OFS_TEST_CTRL, 0, 0, ALL, 0);
		bus(`DCE_OFS_TEST_CLR, 1, {16'h0, w}, 0, 0);
		bus(`DCE_OFS_TEST_CLR, 0, 0, ALL, {16'h0, v});
		bus(`DCE_OFS_TEST_CTRL, 1, 1, 0, 0);
		bus(`DCE_OFS_TEST_CTRL, 0, 0, ALL, 1);
		chk(rco, w);
		bus(`DCE_OFS_TEST_CLR, 0, 0, ALL, {16'h0, w});
		bus(`DCE_OFS_TEST_CTRL, 1, 0, 0, 0);
		for (i = 0; i < 8; i = i + 1)
		begin
			bus(12'h110, 1, i << 11, 0, 0);
			repeat (2) @(posedge hclk);
			chk({sp[0], dp[0], fctl[1:0]}, {1'(8'hdc >> i), 1'(8'hba >> i), 2'(16'ha500 >> 2*i)});
			bus(12'h110, 0, 0, ALL, i << 11);
		end
		c = $urandom % 8;
		ca = 12'(12'h110 + 32 * c);
		bus(`DCE_OFS_IRQ_EN, 1, 0, 0, 0);
		bus(ca, 1, 1, 0, 0);
		bus(`DCE_OFS_ENSUM, 0, 0, ALL, 1 << c);
		pulse(0);
		until_off;
		bus(`DCE_OFS_IRQ_STS, 0, 0, ALL, 1 << c);
		chk(irq, 0);
		bus(`DCE_OFS_IRQ_EN, 1, ALL, 0, 0);
		@(posedge hclk);
		chk(irq, 1);
		bus(`DCE_OFS_IRQ_CLR, 1, ALL, 0, 0);
		@(posedge hclk);
		chk(irq, 0);
		bus(ca, 1, 1, 0, 0);
		pulse(1);
		until_off;
		bus(`DCE_OFS_IRQ_STS, 0, 0, ALL, 1 << (8 + c));
		slow <= 1'b1;
		bus(ca, 1, 1, 0, 0);
		repeat (20) @(posedge hclk);
		bus(ca, 1, 0, 0, 0);
		until_off;
		bus(ca, 0, 0, 1, 0);
		bus(ca, 1, 1, 0, 0);
		repeat (20) @(posedge hclk);
		bus(ca, 1, 32'h40001, 0, 0);
		chk(hlt[c], 1);
		for (i = 0; i < 40; i = i + 1)
			if (i == 0 || rdat[17])
				bus(ca, 0, 0, 0, 0);
		chk(rdat[17], 0);
		if (rdat[17])
			report_and_stop;
		bus(ca, 1, 32'h40000, 0, 0);
		until_off;
		report_and_stop;
	end
endmodule // dce_channel_ctrl_bench
